/* hw/spad_consts.vh */
// Contract
// - Single-phase mode when connection type is wye or delta single-current.
// - Single-phase mode samples only the first current input.
// - Single-phase power factor uses first voltage and first current inputs only.
// - Measured phase difference is corrected by the configured voltage angle offset.
// - Wye options 1..6 give 0, 120, -120, 180, -60, 60 degrees.
// - Delta options 1..6 give -30, 90, -150, 150, -90, 30 degrees.
// - Detection starts only: single-current type, angle undefined, not linear, data view.
// - Detection launches automatically after power-up unless alarm standby holds.
// - Angle set undefined then return to data view restarts detection.
// - First four control outputs disconnected one by one, then discharge awaited.
// - Fixed-off outputs are skipped; next control outputs are used.
// - Outputs switched step by step; each step reports its detected angle.
// - Failed step reports no result; unmatched angle reports inexact estimate.
// - At most 12 rounds of four steps; finish once results are stable.
// - Cancel or alarm aborts detection, discards results, keeps settings.
// - Nominal voltage is nearest of 58, 100, 230, 400, 480, 690 V.
// - Success stores detected angle and nominal voltage in settings.
// - Success returns to initiating state; from control, output recognition follows.
// - Failure or cancel updates nothing; relaunch about every 15 minutes in control.
// - Undercurrent standby blocks detection start.
// - Single-phase power is multiplied by three as three-phase power.
// - Single-phase fixes strategy to three-phase and refuses the CT test.
`ifndef SPAD_CONSTS_VH
`define SPAD_CONSTS_VH
`define ADDR_CONFIG 8'h00
`define ADDR_OUTCFG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RESULT 8'h0C
`define ADDR_POWER 8'h10
`define ADDR_ANGLE 8'h14
`define CONN_THREE 2'h0
`define CONN_WYE_SINGLE 2'h1
`define CONN_DELTA_SINGLE 2'h2
`define ANGLE_UNDEF 3'h0
`define CLK_MHZ 250
`define TICK_US 1000
`define DISCHARGE_MS 30000
`define SETTLE_MS 1000
`define RELAUNCH_MIN 15
`define MAX_ROUNDS 12
`define STEPS_PER_ROUND 4
`define STABLE_HITS 3
`define ANGLE_TOL 9'h00A
`define RES_NONE 2'h0
`define RES_EXACT 2'h1
`define RES_INEXACT 2'h2
`endif

/* hw/single_phase_angle_detect.v */
`timescale 1ns/1ps
`include "spad_consts.vh"
module single_phase_angle_detect #(
  parameter TICK_CYCLES = `TICK_US * `CLK_MHZ,
  parameter DISCHARGE_MS = `DISCHARGE_MS,
  parameter SETTLE_MS = `SETTLE_MS,
  parameter RELAUNCH_MS = `RELAUNCH_MIN * 60 * 1000
) (
  input wire ref_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [7:0] ctrl_cap_i,
  input wire control_mode_i,
  input wire alarm_i,
  input wire standby_i,
  input wire cancel_key_i,
  input wire [15:0] cur1_i,
  input wire [15:0] cur2_i,
  input wire [15:0] cur3_i,
  input wire meas_ok_i,
  input wire signed [8:0] meas_angle_i,
  input wire [15:0] meas_volt_i,
  input wire signed [23:0] p1_i,
  input wire signed [23:0] p3_i,
  input wire ct_test_req_i,
  output reg [7:0] cap_o,
  output reg [15:0] cur_used_o,
  output reg [2:0] cur_en_o,
  output reg signed [8:0] pf_angle_o,
  output reg signed [25:0] power3_o,
  output reg strategy_3p_only_o,
  output reg ct_test_go_o,
  output reg busy_o,
  output reg output_recognition_run_o
);
  localparam S_IDLE = 3'h0;
  localparam S_OFF = 3'h1;
  localparam S_DIS = 3'h2;
  localparam S_ON = 3'h3;
  localparam S_EVAL = 3'h4;

  // ----------------------------------------------------------------
  // Settings and state
  // ----------------------------------------------------------------
  reg [1:0] conn_type;
  reg [2:0] voltage_angle_offset;
  reg linear_mode;
  reg data_view;
  reg data_view_d;
  reg [7:0] fixed_off;
  reg [2:0] nominal_voltage;
  reg [2:0] state;
  reg [7:0] test_mask;
  reg [2:0] idx;
  reg [1:0] nsteps;
  reg [3:0] round;
  reg [7:0] step_on;
  reg [1:0] step_res;
  reg signed [8:0] step_angle;
  reg [2:0] step_opt;
  reg [2:0] last_opt;
  reg [1:0] hits;
  reg [2:0] volt_code;
  reg armed;
  reg from_control;
  reg last_ok;
  reg last_fail;
  reg [17:0] tick_cnt;
  reg tick;
  reg [19:0] ms_cnt;
  reg [19:0] relaunch_cnt;
  reg relaunch_run;

  wire single_phase = (conn_type == `CONN_WYE_SINGLE) || (conn_type == `CONN_DELTA_SINGLE);
  wire start_ok = single_phase && (voltage_angle_offset == `ANGLE_UNDEF) && !linear_mode && data_view;
  wire abort = cancel_key_i || alarm_i;
  wire apb_wr = psel_i && penable_i && pwrite_i && !pready_o;
  wire apb_rd = psel_i && penable_i && !pwrite_i && !pready_o;

  // Offset for an angle option in degrees; undefined gives zero.
  function signed [8:0] offset_of;
    input [1:0] ct;
    input [2:0] opt;
    begin
      if (ct == `CONN_DELTA_SINGLE) begin
        case (opt)
          3'h1: offset_of = -9'sd30;
          3'h2: offset_of = 9'sd90;
          3'h3: offset_of = -9'sd150;
          3'h4: offset_of = 9'sd150;
          3'h5: offset_of = -9'sd90;
          3'h6: offset_of = 9'sd30;
          default: offset_of = 9'h000;
        endcase
      end else begin
        case (opt)
          3'h2: offset_of = 9'sd120;
          3'h3: offset_of = -9'sd120;
          3'h4: offset_of = -9'sd180;
          3'h5: offset_of = -9'sd60;
          3'h6: offset_of = 9'sd60;
          default: offset_of = 9'h000;
        endcase
      end
    end
  endfunction

  // Wrapped difference of two angles, folded into -180..179.
  function signed [9:0] wrap_diff;
    input signed [8:0] a;
    input signed [8:0] b;
    reg signed [10:0] d;
    begin
      d = {{2{a[8]}}, a} - {{2{b[8]}}, b};
      if (d >= 11'sd180) begin
        d = d - 11'sd360;
      end else if (d < -11'sd180) begin
        d = d + 11'sd360;
      end
      wrap_diff = d[9:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Step classification and nominal voltage choice
  // ----------------------------------------------------------------
  reg [2:0] match_opt;
  reg signed [9:0] dd;
  integer k;
  always @* begin
    match_opt = 3'h0;
    dd = 10'h000;
    for (k = 6; k >= 1; k = k - 1) begin
      dd = wrap_diff(meas_angle_i, offset_of(conn_type, k[2:0]));
      if (dd <= $signed({1'b0, `ANGLE_TOL}) && dd >= -$signed({1'b0, `ANGLE_TOL})) begin
        match_opt = k[2:0];
      end
    end
  end

  reg [2:0] next_volt_code;
  always @* begin
    if (meas_volt_i < 16'h004F) begin
      next_volt_code = 3'h0;
    end else if (meas_volt_i < 16'h00A5) begin
      next_volt_code = 3'h1;
    end else if (meas_volt_i < 16'h013B) begin
      next_volt_code = 3'h2;
    end else if (meas_volt_i < 16'h01B8) begin
      next_volt_code = 3'h3;
    end else if (meas_volt_i < 16'h0249) begin
      next_volt_code = 3'h4;
    end else begin
      next_volt_code = 3'h5;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    tick_cnt <= (reset_i || tick) ? 18'h00000 : tick_cnt + 18'h00001;
    tick <= !reset_i && (tick_cnt == TICK_CYCLES[17:0] - 18'h00002);
  end

  // ----------------------------------------------------------------
  // Detection sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= S_IDLE;
      test_mask <= 8'h00;
      idx <= 3'h0;
      nsteps <= 2'h0;
      round <= 4'h0;
      step_on <= 8'h00;
      step_res <= `RES_NONE;
      step_angle <= 9'h000;
      step_opt <= 3'h0;
      last_opt <= 3'h0;
      hits <= 2'h0;
      volt_code <= 3'h0;
      armed <= 1'b1;
      from_control <= 1'b0;
      last_ok <= 1'b0;
      last_fail <= 1'b0;
      ms_cnt <= 20'h00000;
      relaunch_cnt <= 20'h00000;
      relaunch_run <= 1'b0;
      data_view_d <= 1'b0;
      output_recognition_run_o <= 1'b0;
    end else begin
      data_view_d <= data_view;
      output_recognition_run_o <= 1'b0;
      if (data_view && !data_view_d) begin
        armed <= 1'b1;
      end
      if (relaunch_run && tick) begin
        if (relaunch_cnt == RELAUNCH_MS[19:0] - 20'h00001) begin
          relaunch_run <= 1'b0;
          armed <= 1'b1;
        end else begin
          relaunch_cnt <= relaunch_cnt + 20'h00001;
        end
      end
      if (state != S_IDLE && abort) begin
        state <= S_IDLE;
        step_on <= 8'h00;
        last_fail <= 1'b1;
        relaunch_run <= control_mode_i;
        relaunch_cnt <= 20'h00000;
      end else begin
        case (state)
          S_IDLE: begin
            if (armed && start_ok && !standby_i && !alarm_i) begin
              armed <= 1'b0;
              from_control <= control_mode_i;
              last_ok <= 1'b0;
              last_fail <= 1'b0;
              round <= 4'h0;
              hits <= 2'h0;
              last_opt <= 3'h0;
              idx <= 3'h0;
              nsteps <= 2'h0;
              test_mask <= 8'h00;
              state <= S_OFF;
            end
          end
          S_OFF: begin
            // One output per cycle is taken out of control, skipping fixed-off ones.
            if (!fixed_off[idx]) begin
              test_mask[idx] <= 1'b1;
              nsteps <= nsteps + 2'h1;
            end
            idx <= idx + 3'h1;
            if ((!fixed_off[idx] && nsteps == 2'h3) || idx == 3'h7) begin
              state <= S_DIS;
              ms_cnt <= 20'h00000;
              idx <= 3'h0;
            end
          end
          S_DIS: begin
            ms_cnt <= ms_cnt + {19'h00000, tick};
            if (ms_cnt == DISCHARGE_MS[19:0]) begin
              ms_cnt <= 20'h00000;
              if (test_mask == 8'h00) begin
                state <= S_IDLE;
                last_fail <= 1'b1;
                relaunch_run <= control_mode_i;
                relaunch_cnt <= 20'h00000;
              end else begin
                state <= S_ON;
              end
            end
          end
          S_ON: begin
            if (!test_mask[idx]) begin
              idx <= idx + 3'h1;
            end else begin
              step_on <= 8'h01 << idx;
              ms_cnt <= ms_cnt + {19'h00000, tick};
              if (ms_cnt == SETTLE_MS[19:0]) begin
                ms_cnt <= 20'h00000;
                step_on <= 8'h00;
                state <= S_EVAL;
              end
            end
          end
          S_EVAL: begin
            volt_code <= next_volt_code;
            step_angle <= meas_angle_i;
            step_opt <= 3'h0;
            hits <= 2'h0;
            if (!meas_ok_i) begin
              step_res <= `RES_NONE;
            end else if (match_opt == 3'h0) begin
              step_res <= `RES_INEXACT;
            end else begin
              step_res <= `RES_EXACT;
              step_opt <= match_opt;
              last_opt <= match_opt;
              hits <= (match_opt == last_opt) ? hits + 2'h1 : 2'h1;
            end
            idx <= idx + 3'h1;
            state <= S_ON;
            if (meas_ok_i && match_opt != 3'h0 && match_opt == last_opt && hits == `STABLE_HITS - 1) begin
              state <= S_IDLE;
              last_ok <= 1'b1;
              output_recognition_run_o <= from_control;
            end else if (idx == 3'h7 || test_mask[7:0] >> (idx + 3'h1) == 8'h00) begin
              idx <= 3'h0;
              round <= round + 4'h1;
              state <= S_DIS;
              if (round == `MAX_ROUNDS - 1) begin
                state <= S_IDLE;
                last_fail <= 1'b1;
                relaunch_run <= control_mode_i;
                relaunch_cnt <= 20'h00000;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers over APB
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      conn_type <= `CONN_THREE;
      voltage_angle_offset <= `ANGLE_UNDEF;
      linear_mode <= 1'b0;
      data_view <= 1'b0;
      fixed_off <= 8'h00;
      nominal_voltage <= 3'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= 1'b0;
      if (apb_wr) begin
        case (paddr_i)
          `ADDR_CONFIG: begin
            conn_type <= pwdata_i[1:0];
            linear_mode <= pwdata_i[5];
            data_view <= pwdata_i[6];
          end
          `ADDR_OUTCFG: fixed_off <= pwdata_i[7:0];
          `ADDR_ANGLE: begin
            voltage_angle_offset <= pwdata_i[2:0];
            nominal_voltage <= pwdata_i[6:4];
          end
          `ADDR_STATUS, `ADDR_RESULT, `ADDR_POWER: pslverr_o <= 1'b0;
          default: pslverr_o <= 1'b1;
        endcase
      end
      // Hardware store follows software so a finished detection is never lost.
      if (state == S_EVAL && meas_ok_i && match_opt != 3'h0 && match_opt == last_opt
          && hits == `STABLE_HITS - 1 && !abort) begin
        voltage_angle_offset <= match_opt;
        nominal_voltage <= next_volt_code;
      end
      if (apb_rd) begin
        case (paddr_i)
          `ADDR_CONFIG: prdata_o <= {25'h0000000, data_view, linear_mode, 3'h0, conn_type};
          `ADDR_OUTCFG: prdata_o <= {16'h0000, test_mask, fixed_off};
          `ADDR_STATUS: prdata_o <= {12'h000, round, 1'b0, busy_o, last_fail, last_ok, single_phase, state,
                                     2'h0, step_res, 1'b0, step_opt};
          `ADDR_RESULT: prdata_o <= {7'h00, step_angle, 13'h0000, volt_code};
          `ADDR_POWER: prdata_o <= {{6{power3_o[25]}}, power3_o};
          `ADDR_ANGLE: prdata_o <= {25'h0000000, nominal_voltage, 1'b0, voltage_angle_offset};
          default: begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement path and outputs
  // ----------------------------------------------------------------
  wire signed [25:0] p1x3 = ({{2{p1_i[23]}}, p1_i} <<< 1) + {{2{p1_i[23]}}, p1_i};
  wire signed [9:0] corr = wrap_diff(meas_angle_i, offset_of(conn_type, voltage_angle_offset));
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      cap_o <= 8'h00;
      cur_used_o <= 16'h0000;
      cur_en_o <= 3'h7;
      pf_angle_o <= 9'h000;
      power3_o <= 26'h0000000;
      strategy_3p_only_o <= 1'b0;
      ct_test_go_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      cap_o <= (state == S_IDLE) ? ctrl_cap_i : ((ctrl_cap_i & ~test_mask) | step_on);
      cur_en_o <= single_phase ? 3'h1 : 3'h7;
      cur_used_o <= single_phase ? cur1_i : (cur1_i | cur2_i | cur3_i);
      pf_angle_o <= corr[8:0];
      power3_o <= single_phase ? p1x3 : {{2{p3_i[23]}}, p3_i};
      strategy_3p_only_o <= single_phase;
      ct_test_go_o <= ct_test_req_i && !single_phase;
      busy_o <= state != S_IDLE;
    end
  end
endmodule

/* sim/spad_assertions.sv */
`timescale 1ns/1ps
module spad_checker (
  input wire ref_clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pready_o,
  input wire [7:0] ctrl_cap_i,
  input wire control_mode_i,
  input wire alarm_i,
  input wire standby_i,
  input wire cancel_key_i,
  input wire [15:0] cur1_i,
  input wire signed [23:0] p1_i,
  input wire signed [23:0] p3_i,
  input wire ct_test_req_i,
  input wire [7:0] cap_o,
  input wire [15:0] cur_used_o,
  input wire [2:0] cur_en_o,
  input wire signed [25:0] power3_o,
  input wire strategy_3p_only_o,
  input wire ct_test_go_o,
  input wire busy_o,
  input wire output_recognition_run_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // The mode outputs share one register stage, so cur_en_o names the mode of the previous edge.
  property p_ready; psel_i && penable_i && !pready_o |=> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("no answer after access edge");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_cur; cur_en_o == 3'h1 |-> cur_used_o == $past(cur1_i); endproperty
  a_cur: assert property (p_cur) else $error("current not from first input");
  property p_pw1; cur_en_o == 3'h1 |-> power3_o == 26'($past(p1_i)) * 26'sh3; endproperty
  a_pw1: assert property (p_pw1) else $error("single power not tripled");
  property p_pw3; !$past(reset_i) && cur_en_o == 3'h7 |-> power3_o == 26'($past(p3_i)); endproperty
  a_pw3: assert property (p_pw3) else $error("three-phase power wrong");
  property p_ct; !$past(reset_i) |-> ct_test_go_o == ($past(ct_test_req_i) && cur_en_o == 3'h7); endproperty
  a_ct: assert property (p_ct) else $error("ct test gate wrong");
  property p_strat; strategy_3p_only_o == (cur_en_o == 3'h1); endproperty
  a_strat: assert property (p_strat) else $error("strategy flag wrong");
  property p_stby; standby_i [*3] |-> !$rose(busy_o); endproperty
  a_stby: assert property (p_stby) else $error("start during standby");
  property p_abort; busy_o && (cancel_key_i || alarm_i) |-> ##[1:3] !busy_o; endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_idle; (!busy_o && !$past(reset_i)) [*3] |-> cap_o == $past(ctrl_cap_i); endproperty
  a_idle: assert property (p_idle) else $error("outputs not restored");
  property p_orr; output_recognition_run_o |-> control_mode_i ##1 !output_recognition_run_o; endproperty
  a_orr: assert property (p_orr) else $error("recognition pulse wrong");
endmodule
bind single_phase_angle_detect spad_checker chk_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .ctrl_cap_i(ctrl_cap_i), .control_mode_i(control_mode_i),
  .alarm_i(alarm_i), .standby_i(standby_i), .cancel_key_i(cancel_key_i), .cur1_i(cur1_i), .p1_i(p1_i),
  .p3_i(p3_i), .ct_test_req_i(ct_test_req_i), .cap_o(cap_o), .cur_used_o(cur_used_o), .cur_en_o(cur_en_o),
  .power3_o(power3_o), .strategy_3p_only_o(strategy_3p_only_o), .ct_test_go_o(ct_test_go_o), .busy_o(busy_o),
  .output_recognition_run_o(output_recognition_run_o));

/* sim/meas_front_model.sv */
`timescale 1ns/1ps
module meas_front_model (
  input wire ref_clk_i,
  input wire [7:0] cap_i,
  input wire [7:0] ctrl_i,
  input wire [1:0] fail_i,
  input wire signed [8:0] angle_i,
  input wire [15:0] volt_i,
  output logic ok_o,
  output logic signed [8:0] angle_o,
  output logic [15:0] volt_o
);
  logic [1:0] hold = 2'h0;
  logic t = 1'b0;
  // A result lags the relay by one cycle and outlasts it by three, as a real measurement cycle would.
  always @(posedge ref_clk_i) begin
    hold <= |(cap_i & ~ctrl_i) ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
    t <= ~t;
  end
  assign ok_o = hold != 2'h0 && fail_i != 2'h1;
  // Mode 1 scrambles the angle as a failed measurement would.
  // Mode 2 skews by 45 degrees, which lands at least 15 off every table option.
  assign angle_o = fail_i == 2'h1 ? angle_i ^ {9{t}} : fail_i == 2'h2 ? angle_i + (angle_i > 0 ? -9'sd45 : 9'sd45)
                   : angle_i;
  assign volt_o = volt_i;
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "spad_consts.vh"
module testbench;
  logic ref_clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic control_mode_i = 0, alarm_i = 0, standby_i = 0, cancel_key_i = 0, ct_test_req_i = 0;
  logic [7:0] paddr_i = 8'h00, ctrl_cap_i = 8'h00, m;
  logic [31:0] pwdata_i = 32'h0, rd;
  logic [15:0] cur1_i = 16'h0, cur2_i = 16'h0, cur3_i = 16'h0, volt = 16'h0;
  logic signed [23:0] p1_i = 24'h0, p3_i = 24'h0;
  logic signed [8:0] ang = 9'h0;
  logic [1:0] fail = 2'h0;
  wire meas_ok_i, pready_o, pslverr_o, strategy_3p_only_o, ct_test_go_o, busy_o, output_recognition_run_o;
  wire signed [8:0] meas_angle_i, pf_angle_o;
  wire [15:0] meas_volt_i, cur_used_o;
  wire [31:0] prdata_o;
  wire [7:0] cap_o;
  wire [2:0] cur_en_o;
  wire signed [25:0] power3_o;
  int n_errors = 0, n_checks = 0, seed = 32'h79D6, k, v, n_orr = 0, orr0;

  single_phase_angle_detect #(.TICK_CYCLES(10), .DISCHARGE_MS(2), .SETTLE_MS(2), .RELAUNCH_MS(5)) dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .ctrl_cap_i(ctrl_cap_i), .control_mode_i(control_mode_i), .alarm_i(alarm_i), .standby_i(standby_i),
    .cancel_key_i(cancel_key_i), .cur1_i(cur1_i), .cur2_i(cur2_i), .cur3_i(cur3_i), .meas_ok_i(meas_ok_i),
    .meas_angle_i(meas_angle_i), .meas_volt_i(meas_volt_i), .p1_i(p1_i), .p3_i(p3_i),
    .ct_test_req_i(ct_test_req_i), .cap_o(cap_o), .cur_used_o(cur_used_o), .cur_en_o(cur_en_o),
    .pf_angle_o(pf_angle_o), .power3_o(power3_o), .strategy_3p_only_o(strategy_3p_only_o),
    .ct_test_go_o(ct_test_go_o), .busy_o(busy_o), .output_recognition_run_o(output_recognition_run_o));
  meas_front_model model_u (.ref_clk_i(ref_clk_i), .cap_i(cap_o), .ctrl_i(ctrl_cap_i), .fail_i(fail),
    .angle_i(ang), .volt_i(volt), .ok_o(meas_ok_i), .angle_o(meas_angle_i), .volt_o(meas_volt_i));

  initial forever #2 ref_clk_i = ~ref_clk_i;

  // --------------------------------------------------------------
  // Expectations and bus tasks
  // --------------------------------------------------------------
  function int off(int c, int o);
    int w[6] = '{0, 120, -120, -180, -60, 60};
    int d[6] = '{-30, 90, -150, 150, -90, 30};
    return c == 1 ? w[o - 1] : d[o - 1];
  endfunction
  function logic signed [8:0] wrap(int a);
    return 9'(a >= 180 ? a - 360 : (a < -180 ? a + 360 : a));
  endfunction
  function logic [2:0] vc(int x);
    int t[6] = '{58, 100, 230, 400, 480, 690};
    vc = 3'h0;
    for (int i = 1; i < 6; i++) if ((x - t[i]) * (x - t[i]) < (x - t[vc]) * (x - t[vc])) vc = 3'(i);
  endfunction
  function logic [7:0] tmask(logic [7:0] f);
    int n;
    n = 0;
    tmask = 8'h00;
    for (int i = 0; i < 8; i++) if (!f[i] && n < 4) begin
      tmask[i] = 1'b1;
      n++;
    end
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    chk("pready", 1, pready_o);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wb(input logic b, input int lim);
    int n;
    n = 0;
    while (busy_o !== b && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("busy", b, busy_o);
  endtask
  task start(input logic [1:0] c, input logic lin);
    apb(1'b1, `ADDR_ANGLE, {29'h0, `ANGLE_UNDEF});
    apb(1'b1, `ADDR_CONFIG, {26'h0, lin, 3'h0, c});
    apb(1'b1, `ADDR_CONFIG, {26'h1, lin, 3'h0, c});
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cur1_i <= 16'($random(seed));
    cur2_i <= 16'($random(seed));
    cur3_i <= 16'($random(seed));
    p1_i <= 24'($random(seed));
    p3_i <= 24'($random(seed));
    ct_test_req_i <= 1'($random(seed));
    if (output_recognition_run_o === 1'b1) n_orr <= n_orr + 1;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge ref_clk_i);
    chk("reset cur_en", 3'h7, cur_en_o);
    reset_i <= 1'b0;
    apb(1'b0, `ADDR_ANGLE, 32'h0);
    chk("angle reset", 32'h0, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 1, err);
    ctrl_cap_i <= 8'($random(seed));
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `ADDR_CONFIG, 32'(c));
      for (int o = 1; o < 7; o++) begin
        ang <= 9'($random(seed) % 180);
        apb(1'b1, `ADDR_ANGLE, 32'(o));
        repeat (3) @(posedge ref_clk_i);
        chk("cur_en", (c == 1 || c == 2) ? 3'h1 : 3'h7, cur_en_o);
        if (c == 1 || c == 2) chk("pf angle", wrap(ang - off(c, o)), pf_angle_o);
      end
    end
    // Standby, linear mode and a three-phase connection must each alone keep detection from starting.
    for (int b = 0; b < 3; b++) begin
      standby_i <= (b == 0);
      start(b == 2 ? `CONN_THREE : `CONN_DELTA_SINGLE, b == 1);
      repeat (200) @(posedge ref_clk_i);
      chk("no start", 0, busy_o);
      apb(1'b1, `ADDR_CONFIG, 32'h0);
    end
    standby_i <= 1'b0;
    control_mode_i <= 1'b1;
    for (int c = 1; c < 3; c++) begin
      k = 1 + $unsigned($random(seed)) % 6;
      v = $unsigned($random(seed)) % 760;
      if (v inside {79, 165, 315, 440, 585}) v++;
      m = 8'($random(seed)) & 8'h0F;
      apb(1'b1, `ADDR_OUTCFG, {24'h0, m});
      ctrl_cap_i <= 8'($random(seed)) & ~tmask(m);
      ang <= 9'(off(c, k));
      volt <= 16'(v);
      orr0 = n_orr;
      start(2'(c), 1'b0);
      wb(1'b1, 20);
      repeat (8) @(posedge ref_clk_i);
      apb(1'b0, `ADDR_OUTCFG, 32'h0);
      chk("test mask", tmask(m), rd[15:8]);
      wb(1'b0, 3000);
      apb(1'b0, `ADDR_ANGLE, 32'h0);
      chk("angle saved", {vc(v), 1'b0, 3'(k)}, rd[6:0]);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk("step", {2'h3, `RES_EXACT, 3'(k)}, {rd[12:11], rd[5:4], rd[2:0]});
      chk("recognition", 1, n_orr - orr0);
    end
    control_mode_i <= 1'b0;
    for (int f = 1; f < 3; f++) begin
      fail <= 2'(f);
      start(`CONN_WYE_SINGLE, 1'b0);
      wb(1'b1, 20);
      wb(1'b0, 4000);
      apb(1'b0, `ADDR_ANGLE, 32'h0);
      chk("angle kept", 0, rd[6:0]);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk("fail", {1'b1, f == 1 ? `RES_NONE : `RES_INEXACT}, {rd[13], rd[5:4]});
    end
    fail <= 2'h0;
    control_mode_i <= 1'b1;
    orr0 = n_orr;
    start(`CONN_WYE_SINGLE, 1'b0);
    wb(1'b1, 20);
    repeat (30) @(posedge ref_clk_i);
    cancel_key_i <= 1'b1;
    wb(1'b0, 5);
    cancel_key_i <= 1'b0;
    apb(1'b0, `ADDR_ANGLE, 32'h0);
    chk("angle kept", 0, rd[6:0]);
    chk("no recognition", 0, n_orr - orr0);
    wb(1'b1, 150);
    control_mode_i <= 1'b0;
    alarm_i <= 1'b1;
    wb(1'b0, 5);
    alarm_i <= 1'b0;
    end_sim;
  end
endmodule
